// File: bench/capture_compare_pwm_unit_sva.sv
// Port-level checks of the capture/compare/PWM unit
`timescale 1ns/100ps
module capture_compare_pwm_unit_sva
(
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  input wire logic i_sleep,
  input wire logic [15:0] i_event_timer,
  input wire logic [7:0] o_unit_control,
  input wire logic [15:0] o_match_value_pair,
  input wire logic o_unit_flag,
  input wire logic o_pin_out,
  input wire logic o_pin_oe,
  input wire logic o_special_trigger,
  input wire logic o_adc_start,
  input wire logic o_event_timer_reset,
  input wire logic [7:0] o_pwm_timer,
  input wire logic o_pwm_period_end
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rstn);
  logic [3:0] mode;
  // Mode held for two cycles gives the registered pin enable time to follow
  assign mode = o_unit_control[3:0];
  AST_ADC_WITH_TRIG: assert property (o_adc_start |-> o_special_trigger)
    else $error("adc start without trigger");
  AST_TRIG_PULSE: assert property (o_special_trigger |=> !o_special_trigger)
    else $error("trigger longer than one cycle");
  AST_TRIG_EFFECTS: assert property (o_special_trigger |-> o_unit_flag && o_event_timer_reset
    && $past(mode) == 4'hB)
    else $error("trigger without flag, reset request or mode");
  AST_OFF_RELEASE: assert property ((mode == 4'h0) [*2] |-> !o_pin_oe && !o_pin_out)
    else $error("pin held while unit off");
  AST_SOFT_NO_PIN: assert property ((mode == 4'hA || mode == 4'hB) [*2] |-> !o_pin_oe)
    else $error("pin taken in flag or trigger mode");
  AST_CAPTURE_VALUE: assert property ($rose(o_unit_flag) && mode[3:2] == 2'b01
    |-> o_match_value_pair == $past(i_event_timer))
    else $error("captured value differs from timer");
  AST_WRAP_CLEARS: assert property (o_pwm_period_end |-> o_pwm_timer == 8'h00)
    else $error("pwm timer not cleared at period end");
  AST_SLEEP_HOLD: assert property (i_sleep && $past(i_sleep)
    |-> $stable(o_pwm_timer) && $stable(o_pin_out))
    else $error("state moved during sleep");
endmodule // capture_compare_pwm_unit_sva
bind capture_compare_pwm_unit capture_compare_pwm_unit_sva chk (.i_ref_clk, .i_rstn, .i_sleep,
  .i_event_timer, .o_unit_control, .o_match_value_pair, .o_unit_flag, .o_pin_out, .o_pin_oe,
  .o_special_trigger, .o_adc_start, .o_event_timer_reset, .o_pwm_timer, .o_pwm_period_end);

// File: bench/capture_compare_pwm_unit_test.sv
// Self-checking bench for the capture/compare/PWM unit
`timescale 1ns/100ps
module capture_compare_pwm_unit_test;
  logic i_ref_clk = 1'b0;
  logic i_rstn = 1'b0;
  logic c_wr = 1'b0, d_wr = 1'b0, s_wr = 1'b0, f_clr = 1'b0, sleep = 1'b0;
  logic run = 1'b0, clr = 1'b0, level = 1'b0, adc_en = 1'b1;
  logic [7:0] c_data = 8'h00, d_data = 8'h00, s_data = 8'h00, limit = 8'h01, ctrl, pwm_t;
  logic [1:0] psc = 2'h0;
  logic pin, pin_out, pin_oe, trig, adc, ev_rst, flag, pend, tick;
  logic [15:0] pair, timer;
  int err_total = 0, compares = 0, adc_n = 0;

  always #4 i_ref_clk = ~i_ref_clk;
  // Counts start requests so a doubled pulse is seen
  always @(posedge i_ref_clk)
    if (adc === 1'b1)
      adc_n++;

  capture_compare_pwm_unit dut
  (
    .i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_control_wr(c_wr), .i_control_data(c_data),
    .i_duty_high_wr(d_wr), .i_duty_high_data(d_data), .i_shadow_wr(s_wr),
    .i_shadow_data(s_data), .i_flag_clear(f_clr), .i_event_timer(timer),
    .i_event_timer_tick(tick), .i_adc_enable(adc_en), .i_period_limit(limit),
    .i_pwm_timer_on(1'b1), .i_pwm_prescale(psc), .i_sleep(sleep), .i_pin(pin),
    .o_unit_control(ctrl), .o_match_value_pair(pair), .o_unit_flag(flag), .o_pin_out(pin_out),
    .o_pin_oe(pin_oe), .o_special_trigger(trig), .o_adc_start(adc),
    .o_event_timer_reset(ev_rst), .o_pwm_timer(pwm_t), .o_pwm_period_end(pend)
  );
  cc_far_side far
  (
    .i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_run(run), .i_clear(clr), .i_level(level),
    .i_pin_out(pin_out), .i_pin_oe(pin_oe), .i_timer_reset(ev_rst), .o_pin(pin),
    .o_timer(timer), .o_tick(tick)
  );

  task close_out;
    $display("errors %0d compares %0d", err_total, compares);
    if (err_total == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      err_total++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task cyc(input int n);
    repeat (n) @(negedge i_ref_clk);
  endtask

  // One strobe: 0 control, 1 duty high, 2 shadow, 3 flag clear
  task wr(input int sel, input logic [7:0] data);
    @(negedge i_ref_clk);
    c_data = data;
    d_data = data;
    s_data = data;
    c_wr = (sel == 0);
    d_wr = (sel == 1);
    s_wr = (sel == 2);
    f_clr = (sel == 3);
    @(negedge i_ref_clk);
    c_wr = 1'b0;
    d_wr = 1'b0;
    s_wr = 1'b0;
    f_clr = 1'b0;
  endtask

  // Bounded wait: 0 for the unit flag, 1 for a period end
  task wait_on(input int sel);
    for (int i = 0; i < 400; i++)
    begin
      cyc(1);
      if ((sel == 0 ? flag : pend) === 1'b1)
        break;
    end
  endtask

  task pulse;
    level = 1'b1;
    cyc(4);
    level = 1'b0;
    cyc(4);
  endtask

  // Each capture mode fires on its own edge count, from a cleared prescaler
  task t_capture;
    logic [3:0] modes [4] = '{4'h4, 4'h5, 4'h6, 4'h7};
    int edges [4] = '{1, 1, 4, 16};
    for (int m = 0; m < 4; m++)
    begin
      wr(0, 8'h00);
      wr(3, 8'h00);
      wr(0, {4'h0, modes[m]});
      run = 1'b1;
      cyc(9);
      run = 1'b0;
      for (int e = 0; e < edges[m]; e++)
      begin
        check(flag, 1'b0);
        pulse();
      end
      check(flag, 1'b1);
      check(pair, timer);
    end
  endtask

  task cmp(input logic [3:0] mode, input logic exp_pin, input logic exp_oe);
    run = 1'b0;
    clr = 1'b1;
    cyc(1);
    clr = 1'b0;
    wr(3, 8'h00);
    wr(0, {4'h0, mode});
    run = 1'b1;
    wait_on(0);
    cyc(3);
    run = 1'b0;
    check(flag, 1'b1);
    check(pin_out, exp_pin);
    check(pin_oe, exp_oe);
  endtask

  // Mode changes without clearing keep the latch, so toggles build on it
  task t_compare;
    wr(2, 8'h00);
    wr(1, 8'h10);
    cmp(4'h8, 1'b1, 1'b1);
    wr(0, 8'h00);
    cyc(2);
    check(pin_out, 1'b0);
    check(pin_oe, 1'b0);
    cmp(4'h8, 1'b1, 1'b1);
    cmp(4'h9, 1'b0, 1'b1);
    cmp(4'h2, 1'b1, 1'b1);
    cmp(4'h2, 1'b0, 1'b1);
    cmp(4'hA, 1'b0, 1'b0);
    cmp(4'hB, 1'b0, 1'b0);
    check(adc_n, 16'h0001);
    check(timer < 16'h0010, 1'b1);
  endtask

  // Duty table covers a plain width, 0% and a width far past the period
  task t_pwm;
    logic [9:0] duty [4] = '{10'h004, 10'h003, 10'h000, 10'h3FC};
    int highs [4] = '{4, 3, 0, 8};
    int n;
    for (int k = 0; k < 4; k++)
    begin
      wr(1, duty[k][9:2]);
      wr(0, {2'h0, duty[k][1:0], 4'hC});
      wr(2, 8'h5A);
      wait_on(1);
      wait_on(1);
      check(pair[15:8], duty[k][9:2]);
      n = 0;
      repeat (8)
      begin
        n += pin_out;
        cyc(1);
      end
      check(n, highs[k]);
    end
    for (int p = 0; p < 3; p++)
    begin
      psc = p[1:0];
      wait_on(1);
      wait_on(1);
      n = 0;
      do
      begin
        cyc(1);
        n++;
      end
      while (pend !== 1'b1 && n < 300);
      check(n, 8 << (2 * p));
    end
    n = pwm_t;
    sleep = 1'b1;
    cyc(20);
    check(pwm_t, n[7:0]);
    sleep = 1'b0;
    cyc(4);
  endtask

  initial
  begin
    cyc(8);
    i_rstn = 1'b1;
    t_capture();
    t_compare();
    t_pwm();
    close_out();
  end

  // Whole run needs about a thousand cycles; this bound is far beyond
  initial
  begin
    #400000;
    err_total++;
    close_out();
  end
endmodule // capture_compare_pwm_unit_test

// File: bench/cc_far_side.sv
// Far side of the unit: pin source and synchronous event timer
`timescale 1ns/100ps
module cc_far_side
(
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  input wire logic i_run,
  input wire logic i_clear,
  input wire logic i_level,
  input wire logic i_pin_out,
  input wire logic i_pin_oe,
  input wire logic i_timer_reset,
  output logic o_pin,
  output logic [15:0] o_timer,
  output logic o_tick
);
  // Timer steps on the unit clock only, never as a free counter
  always_ff @(posedge i_ref_clk or negedge i_rstn)
    if (!i_rstn)
      o_timer <= 16'h0000;
    else if (i_clear)
      o_timer <= 16'h0000;
    else if (i_run)
      o_timer <= i_timer_reset ? 16'h0000 : o_timer + 16'h0001;
  // Reset request is only taken on a step, so tick follows run
  assign o_tick = i_run;
  // Wire level: unit drives while enabled, the source otherwise
  assign o_pin = i_pin_oe ? i_pin_out : i_level;
endmodule // cc_far_side

// File: logic/capture_compare_pwm_pkg.sv
// Types shared by the capture/compare/PWM unit
package capture_compare_pwm_pkg;

  // Operating class of the unit, decoded from the mode select field
  typedef enum logic [3:0]
  {
    ST_OFF = 4'h1,
    ST_CAPTURE = 4'h2,
    ST_COMPARE = 4'h4,
    ST_PWM = 4'h8
  } unit_state_t;

endpackage

// File: logic/capture_compare_pwm_unit.sv
// Capture/compare/PWM unit: pin capture, timer compare and PWM generation
`timescale 1ns/100ps
`include "cc_pwm_defines.svh"

// Operation
// RULE1: Selected pin event copies event timer into value pair and sets flag.
// RULE2: Capture modes: falling, rising, every fourth rising, every sixteenth rising edge.
// RULE3: Edge prescaler cleared when off, not capturing, or at reset.
// RULE4: Switching between capture prescales keeps the count; false events possible.
// RULE5: Event timer must be synchronous for capture and compare to work.
// RULE6: Compare mode matches value against timer; toggles, sets, clears or triggers.
// RULE7: Every compare match sets the unit flag.
// RULE8: Clearing unit control forces the compare output latch low.
// RULE9: Software interrupt mode only sets the flag, pin left alone.
// RULE10: Trigger mode resets event timer, starts ADC if enabled, pin left alone.
// RULE11: Trigger is immediate; timer reset waits for the next timer clock.
// RULE12: The trigger never sets the event timer overflow flag.
// RULE13: Removing the match before the timer clock cancels the timer reset.
// RULE14: PWM mode drives a pulse-width output of up to ten bits.
// RULE15: Clearing unit control releases the pin.
// RULE16: Period is limit plus one, times four clocks, times prescale.
// RULE17: At period end timer clears, pin sets unless duty zero, shadow loads.
// RULE18: Duty is high byte plus two control bits, applied at period end.
// RULE19: Duty shadow cannot be written by software while in PWM mode.
// RULE20: Duty is double buffered in shadow and a two-bit latch.
// RULE21: PWM timer extended by clock phase or prescaler bits to ten bits.
// RULE22: Time base equal to buffered duty clears the PWM pin.
// RULE23: Pulse width beyond the period leaves the pin unchanged.
// RULE24: In sleep the PWM timer and unit state hold; pin keeps value.
// RULE25: ADC start is one clock pulse per trigger match.
module capture_compare_pwm_unit
  import capture_compare_pwm_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  input wire logic i_control_wr,
  input wire logic [7:0] i_control_data,
  input wire logic i_duty_high_wr,
  input wire logic [7:0] i_duty_high_data,
  input wire logic i_shadow_wr,
  input wire logic [7:0] i_shadow_data,
  input wire logic i_flag_clear,
  input wire logic [15:0] i_event_timer,
  input wire logic i_event_timer_tick,
  input wire logic i_adc_enable,
  input wire logic [7:0] i_period_limit,
  input wire logic i_pwm_timer_on,
  input wire logic [1:0] i_pwm_prescale,
  input wire logic i_sleep,
  input wire logic i_pin,
  output logic [7:0] o_unit_control,
  output logic [15:0] o_match_value_pair,
  output logic o_unit_flag,
  output logic o_pin_out,
  output logic o_pin_oe,
  output logic o_special_trigger,
  output logic o_adc_start,
  output logic o_event_timer_reset,
  output logic [7:0] o_pwm_timer,
  output logic o_pwm_period_end
);

  // Class of a mode select value; reserved codes count as off
  function automatic unit_state_t mode_class(input logic [3:0] mode);
    unit_state_t cls;
    cls = ST_OFF;
    case (mode)
      `MODE_CAP_FALL, `MODE_CAP_RISE, `MODE_CAP_RISE4, `MODE_CAP_RISE16:
        cls = ST_CAPTURE;
      `MODE_CMP_TOGGLE, `MODE_CMP_SET, `MODE_CMP_CLEAR, `MODE_CMP_SOFT, `MODE_CMP_TRIG:
        cls = ST_COMPARE;
      default:
        cls = (mode[3:2] == `MODE_PWM_PREFIX) ? ST_PWM : ST_OFF;
    endcase
    return cls;
  endfunction

  logic [7:0] unit_control;
  logic [7:0] next_unit_control;
  logic [7:0] duty_high_byte;
  logic [7:0] next_duty_high_byte;
  logic [7:0] duty_shadow;
  logic [7:0] next_duty_shadow;
  logic [1:0] duty_latch;
  logic [1:0] next_duty_latch;
  logic unit_flag;
  logic next_unit_flag;
  unit_state_t unit_state;
  unit_state_t next_unit_state;

  logic pin_sync1;
  logic pin_sync2;
  logic pin_prev;
  logic [3:0] cap_count;
  logic [3:0] next_cap_count;
  logic pin_rise;
  logic pin_fall;
  logic cap_event;

  logic out_latch;
  logic next_out_latch;
  logic pin_oe;
  logic next_pin_oe;
  logic match_prev;
  logic special;
  logic next_special;
  logic adc_start;
  logic next_adc_start;
  logic reset_req;
  logic next_reset_req;
  logic period_end;

  logic [3:0] mode;
  logic match_now;
  logic cmp_hit;
  logic pwm_wrap;
  logic [15:0] next_pair;
  logic [9:0] time_base;
  logic [9:0] duty_buf;
  logic [9:0] duty_req;

  pwm_tb_if tb ();

  // PWM timer runs only while enabled and awake [RULE24]
  assign tb.run = i_pwm_timer_on && !i_sleep;
  assign tb.prescale = i_pwm_prescale;
  assign tb.limit = i_period_limit;

  pwm_time_base u_time_base
  (
    .i_ref_clk(i_ref_clk),
    .i_rstn(i_rstn),
    .tb(tb.base)
  );

  // Decoded views of the registers and the time base
  assign mode = unit_control[`CTRL_MODE_MSB:`CTRL_MODE_LSB];
  assign duty_req = {duty_high_byte, unit_control[`CTRL_DUTY_MSB:`CTRL_DUTY_LSB]};
  assign duty_buf = {duty_shadow, duty_latch};
  assign time_base = {tb.timer, tb.fine}; // [RULE21]
  assign pwm_wrap = (unit_state == ST_PWM) && tb.wrap;
  // Event timer is assumed synchronous to this clock [RULE5]
  assign match_now = (i_event_timer == {duty_shadow, duty_high_byte});
  // One hit per match, however long the timer rests on the value [RULE6]
  assign cmp_hit = (unit_state == ST_COMPARE) && match_now && !match_prev && !i_sleep;

  // Edge detect reads only the second and later sync stages
  assign pin_rise = pin_sync2 && !pin_prev;
  assign pin_fall = !pin_sync2 && pin_prev;

  // Capture event selection by mode [RULE2]
  always_comb
  begin
    cap_event = 1'b0;
    if ((unit_state == ST_CAPTURE) && !i_sleep)
    begin
      case (mode)
        `MODE_CAP_FALL: cap_event = pin_fall;
        `MODE_CAP_RISE: cap_event = pin_rise;
        `MODE_CAP_RISE4: cap_event = pin_rise && (cap_count[1:0] == `CAP_DIV4_LAST);
        `MODE_CAP_RISE16: cap_event = pin_rise && (cap_count == `CAP_DIV16_LAST);
        default: cap_event = 1'b0;
      endcase
    end
  end

  // Register file next values
  always_comb
  begin
    next_unit_control = unit_control;
    next_duty_high_byte = duty_high_byte;
    next_duty_shadow = duty_shadow;
    next_duty_latch = duty_latch;
    next_unit_flag = unit_flag;
    if (i_control_wr)
      next_unit_control = i_control_data & `CTRL_WR_MASK;
    if (i_duty_high_wr)
      next_duty_high_byte = i_duty_high_data; // [RULE18]
    if (i_shadow_wr && (unit_state != ST_PWM))
      next_duty_shadow = i_shadow_data; // [RULE19]
    // Duty reaches the comparator only at the period boundary
    if (pwm_wrap)
    begin
      next_duty_shadow = duty_req[9:2]; // [RULE17] [RULE18] [RULE20]
      next_duty_latch = duty_req[1:0]; // [RULE20]
    end
    // Capture beats a same-cycle software write; newest capture overwrites
    if (cap_event)
    begin
      next_duty_shadow = i_event_timer[15:8]; // [RULE1]
      next_duty_high_byte = i_event_timer[7:0]; // [RULE1]
    end
    // Hardware set wins over a same-cycle clear
    if (i_flag_clear)
      next_unit_flag = 1'b0;
    if (cap_event || cmp_hit)
      next_unit_flag = 1'b1; // [RULE1] [RULE7] [RULE9]
    next_unit_state = mode_class(next_unit_control[`CTRL_MODE_MSB:`CTRL_MODE_LSB]);
  end

  assign next_pair = {next_duty_shadow, next_duty_high_byte};

  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      unit_control <= `CTRL_RESET;
      duty_high_byte <= `BYTE_RESET;
      duty_shadow <= `BYTE_RESET;
      duty_latch <= 2'h0;
      unit_flag <= 1'b0;
      unit_state <= ST_OFF;
    end
    else
    begin
      unit_control <= next_unit_control;
      duty_high_byte <= next_duty_high_byte;
      duty_shadow <= next_duty_shadow;
      duty_latch <= next_duty_latch;
      unit_flag <= next_unit_flag;
      unit_state <= next_unit_state;
    end
  end

  // Edge prescaler: counts rising edges only while capturing
  always_comb
  begin
    next_cap_count = cap_count;
    if (unit_state != ST_CAPTURE)
      next_cap_count = `CAP_COUNT_RESET; // [RULE3]
    else if (pin_rise && !i_sleep)
      next_cap_count = 4'(cap_count + 4'h1); // [RULE4]
  end

  // Pin passes two flops before any logic looks at it
  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      pin_sync1 <= 1'b0;
      pin_sync2 <= 1'b0;
      pin_prev <= 1'b0;
      cap_count <= `CAP_COUNT_RESET; // [RULE3]
    end
    else
    begin
      pin_sync1 <= i_pin;
      pin_sync2 <= pin_sync1;
      pin_prev <= pin_sync2;
      cap_count <= next_cap_count;
    end
  end

  // Output latch, pin ownership and trigger outputs
  always_comb
  begin
    next_out_latch = out_latch;
    next_pin_oe = 1'b0;
    next_special = 1'b0;
    next_adc_start = 1'b0;
    next_reset_req = reset_req;
    case (unit_state)
      ST_COMPARE:
      begin
        // Only set, clear and toggle modes own the pin [RULE9] [RULE10]
        next_pin_oe = (mode == `MODE_CMP_TOGGLE) || (mode == `MODE_CMP_SET) ||
          (mode == `MODE_CMP_CLEAR);
        if (cmp_hit)
        begin
          case (mode)
            `MODE_CMP_TOGGLE: next_out_latch = !out_latch; // [RULE6]
            `MODE_CMP_SET: next_out_latch = 1'b1; // [RULE6]
            `MODE_CMP_CLEAR: next_out_latch = 1'b0; // [RULE6]
            `MODE_CMP_TRIG:
            begin
              next_special = 1'b1; // [RULE11]
              next_adc_start = i_adc_enable; // [RULE10] [RULE25]
            end
            default: next_out_latch = out_latch;
          endcase
        end
      end
      ST_PWM:
      begin
        next_pin_oe = 1'b1; // [RULE14]
        // Set and clear both lag the time base by one clock, so the width is exact;
        // sleep freezes the pin together with the timer
        if (i_sleep)
          next_out_latch = out_latch; // [RULE24]
        else if (period_end)
          next_out_latch = (duty_buf != `DUTY_ZERO); // [RULE17]
        else if (time_base == duty_buf)
          next_out_latch = 1'b0; // [RULE22] [RULE23]
      end
      ST_CAPTURE:
        next_out_latch = out_latch;
      default:
        next_out_latch = 1'b0; // [RULE8] [RULE15]
    endcase
    // Reset request waits for the timer clock and dies if the match goes away;
    // it is a separate line, so the overflow flag is never touched [RULE12]
    if (cmp_hit && (mode == `MODE_CMP_TRIG))
      next_reset_req = 1'b1; // [RULE10] [RULE11]
    else if (i_event_timer_tick || (i_event_timer != next_pair) ||
      (unit_state != ST_COMPARE) || (mode != `MODE_CMP_TRIG))
      next_reset_req = 1'b0; // [RULE11] [RULE13]
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      out_latch <= 1'b0;
      pin_oe <= 1'b0;
      match_prev <= 1'b0;
      special <= 1'b0;
      adc_start <= 1'b0;
      reset_req <= 1'b0;
      period_end <= 1'b0;
    end
    else
    begin
      out_latch <= next_out_latch; // [RULE24]
      pin_oe <= next_pin_oe;
      match_prev <= match_now;
      special <= next_special;
      adc_start <= next_adc_start;
      reset_req <= next_reset_req;
      period_end <= tb.wrap;
    end
  end

  // All outputs come from flops here or in the time base
  assign o_unit_control = unit_control;
  assign o_match_value_pair = {duty_shadow, duty_high_byte};
  assign o_unit_flag = unit_flag;
  assign o_pin_out = out_latch;
  assign o_pin_oe = pin_oe;
  assign o_special_trigger = special;
  assign o_adc_start = adc_start;
  assign o_event_timer_reset = reset_req;
  assign o_pwm_timer = tb.timer;
  assign o_pwm_period_end = period_end;

endmodule // capture_compare_pwm_unit

// File: logic/cc_pwm_defines.svh
// Named constants for the capture/compare/PWM unit
`ifndef CC_PWM_DEFINES_SVH
`define CC_PWM_DEFINES_SVH

// Mode select codes
`define MODE_OFF 4'h0
`define MODE_CMP_TOGGLE 4'h2
`define MODE_CAP_FALL 4'h4
`define MODE_CAP_RISE 4'h5
`define MODE_CAP_RISE4 4'h6
`define MODE_CAP_RISE16 4'h7
`define MODE_CMP_SET 4'h8
`define MODE_CMP_CLEAR 4'h9
`define MODE_CMP_SOFT 4'hA
`define MODE_CMP_TRIG 4'hB
`define MODE_PWM_PREFIX 2'h3

// Unit control field layout and reset values
`define CTRL_MODE_MSB 3
`define CTRL_MODE_LSB 0
`define CTRL_DUTY_MSB 5
`define CTRL_DUTY_LSB 4
`define CTRL_WR_MASK 8'h3F
`define CTRL_RESET 8'h00
`define BYTE_RESET 8'h00
`define DUTY_ZERO 10'h000

// Capture edge prescaler terminal counts
`define CAP_COUNT_RESET 4'h0
`define CAP_DIV4_LAST 2'h3
`define CAP_DIV16_LAST 4'hF

// PWM time base: four clock phases per instruction cycle, prescale 1, 4 or 16
`define PHASE_LAST 2'h3
`define PSC_DIV1 2'h0
`define PSC_DIV4 2'h1
`define PRE4_LAST 2'h3
`define PRE16_LAST 4'hF

`endif

// File: logic/pwm_tb_if.sv
// Link between the unit and its PWM time base
`timescale 1ns/100ps
interface pwm_tb_if;
  logic run;
  logic [1:0] prescale;
  logic [7:0] limit;
  logic [7:0] timer;
  logic [1:0] fine;
  logic wrap;

  modport base (input run, input prescale, input limit, output timer, output fine, output wrap);
  modport user (output run, output prescale, output limit, input timer, input fine, input wrap);
endinterface

// File: logic/pwm_time_base.sv
// PWM timer with prescaler and 10-bit time base extension
`timescale 1ns/100ps
`include "cc_pwm_defines.svh"

module pwm_time_base
(
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  pwm_tb_if.base tb
);

  logic [1:0] phase;
  logic [1:0] next_phase;
  logic [3:0] pre;
  logic [3:0] next_pre;
  logic [7:0] timer;
  logic [7:0] next_timer;
  logic cycle_end;
  logic inc;

  // One instruction cycle is four clock phases; frozen while not running
  assign cycle_end = tb.run && (phase == `PHASE_LAST);

  // Timer step after prescale 1, 4 or 16 instruction cycles [RULE16]
  always_comb
  begin
    inc = 1'b0;
    case (tb.prescale)
      `PSC_DIV1: inc = cycle_end;
      `PSC_DIV4: inc = cycle_end && (pre[1:0] == `PRE4_LAST);
      default: inc = cycle_end && (pre == `PRE16_LAST);
    endcase
  end

  // Next state of phase, prescaler and timer; sleep stops all of them [RULE24]
  always_comb
  begin
    next_phase = phase;
    next_pre = pre;
    next_timer = timer;
    if (tb.run)
      next_phase = 2'(phase + 2'h1);
    if (inc)
      next_pre = 4'h0;
    else if (cycle_end)
      next_pre = 4'(pre + 4'h1);
    if (inc && (timer == tb.limit))
      next_timer = 8'h00; // [RULE17]
    else if (inc)
      next_timer = 8'(timer + 8'h01);
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      phase <= 2'h0;
      pre <= 4'h0;
      timer <= `BYTE_RESET;
    end
    else
    begin
      phase <= next_phase;
      pre <= next_pre;
      timer <= next_timer;
    end
  end

  // Fine bits: clock phase at 1:1, prescaler low two bits at 1:4, its top two bits at 1:16 [RULE21]
  always_comb
  begin
    case (tb.prescale)
      `PSC_DIV1: tb.fine = phase;
      `PSC_DIV4: tb.fine = pre[1:0];
      default: tb.fine = pre[3:2];
    endcase
  end

  assign tb.timer = timer;
  // Wrap marks the step that clears the timer; the user loads duty in that cycle and sees period end one cycle later
  assign tb.wrap = inc && (timer == tb.limit);

endmodule // pwm_time_base
